// ==== core/adc_cfg_device.sv ====
// Purpose: converter end: serial register bank, test pattern generator, heat readout
// Assumes: link pins sampled by clk through three flops, frame is r/w, 2 spare, 13 addr, 8 data
// Notes:   bytes after the first in a frame go to following addresses until the stop address
//
// Local design decision: the APB slave port.
`include "adc_cfg_consts.svh"

module adc_cfg_device
   import adc_cfg_pkg::*;
#(
   parameter int         OUT_W    = 12,
   parameter logic [7:0] PART_ID  = 8'h5A, // arbitrary value
   parameter logic [7:0] PART_REV = 8'h01  // arbitrary value
)(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // serial link
   spi_link_if.dev               link,
   // conversion data, sample timing and die heat reading
   input  wire logic [OUT_W-1:0] convData,
   input  wire logic             sampleStrobe,
   input  wire logic [15:0]      dieHeat,
   // output bus
   output      logic [OUT_W-1:0] dataOut,
   output      logic             dataValid,
   // control outputs
   output      logic             dllSlow,
   output      logic             ddrEnable,
   output      logic [1:0]       coreSelect,
   output      logic             sensorPower
);

   dev_state_type q;
   dev_state_type d;
   logic          sclkRise;
   logic          sclkFall;
   logic [15:0]   instr;
   logic [7:0]    dataByte;
   logic [12:0]   nextAddr;
   logic [15:0]   word1;
   logic [15:0]   word2;
   logic          useWord;
   logic          altWord;

   // ==========================================================
   // read decode
   function automatic logic [7:0] readByte(input logic [12:0] a, input dev_state_type s,
                                           input logic [15:0] heat);
      logic [7:0] r;
      logic       ext;
      r   = 8'h00;
      ext = s.coreIndex[`BIT_EXT_PAGE];
      case (a)
         `OFS_SERIAL_PORT_SETUP:  r = s.portSetup;
         `OFS_BURST_STOP_ADDRESS: r = s.burstStop; // RULE_16
         `OFS_PART_IDENTIFIER:    r = PART_ID;
         `OFS_PART_REVISION:      r = PART_REV;
         `OFS_CORE_SELECT_INDEX:  r = s.coreIndex;
         // readback carries the range bit folded in, undone by the host's xor
         `OFS_AUX_OUTPUT_SETTING: r = s.auxEff ^ s.setupState; // RULE_03
         `OFS_SETUP_AND_STATE:    r = s.setupState;
         `OFS_PATTERN_SELECT:     r = s.patSel;
         `OFS_CUSTOM_ONE_LOW:     r = s.customOne[7:0];
         `OFS_CUSTOM_ONE_HIGH:    r = s.customOne[15:8];
         `OFS_CUSTOM_TWO_LOW:     r = s.customTwo[7:0];
         `OFS_CUSTOM_TWO_HIGH:    r = s.customTwo[15:8];
         // sensor off or page closed reads zero
         `OFS_HEAT_LOW:  r = (ext && s.sensorOn) ? heat[7:0] : 8'h00; // RULE_14
         `OFS_HEAT_HIGH: r = (ext && s.sensorOn) ? heat[15:8] : 8'h00; // RULE_14
         default:                 r = 8'h00;
      endcase
      return r;
   endfunction

   // ==========================================================
   // pattern words
   always_comb begin
      word1   = `WORD_ZEROS;
      word2   = `WORD_ZEROS;
      useWord = 1'b0;
      altWord = 1'b0;
      case (q.patSel[3:0]) // RULE_08
         `PAT_MID: begin
            word1   = `WORD_MID; // RULE_09
            useWord = 1'b1;
         end
         `PAT_POS: begin
            word1   = `WORD_ONES; // RULE_09
            useWord = 1'b1;
         end
         `PAT_NEG: begin
            word1   = `WORD_ZEROS; // RULE_09
            useWord = 1'b1;
         end
         `PAT_CHECKER: begin
            word1   = `WORD_CHECK_A; // RULE_10
            word2   = `WORD_CHECK_B;
            useWord = 1'b1;
            altWord = 1'b1;
         end
         `PAT_ONE_ZERO: begin
            word1   = `WORD_ONES; // RULE_10
            word2   = `WORD_ZEROS;
            useWord = 1'b1;
            altWord = 1'b1;
         end
         `PAT_CUSTOM: begin
            word1 = q.customOne; // RULE_11
            word2 = q.customTwo; // RULE_12
            case (q.patSel[7:6]) // RULE_07
               `CUSTOM_STATIC: begin
                  useWord = 1'b1;
               end
               `CUSTOM_ALTERNATE: begin
                  useWord = 1'b1;
                  altWord = 1'b1;
               end
               default: begin
                  useWord = 1'b0; // RULE_18
               end
            endcase
         end
         default: begin
            useWord = 1'b0; // RULE_18
         end
      endcase
   end

   // ==========================================================
   // next state
   always_comb begin
      d        = q;
      instr    = {q.shiftIn[14:0], q.mosiF};
      dataByte = {q.shiftIn[6:0], q.mosiF};
      nextAddr = q.addr + 13'h001;
      // link pins: a change counts once the second and third flop agree
      d.sclkSync = {q.sclkSync[1:0], link.sclk};
      d.csnSync  = {q.csnSync[1:0], link.csnN};
      d.mosiSync = {q.mosiSync[1:0], link.mosi};
      if (q.sclkSync[2] == q.sclkSync[1]) begin
         d.sclkF = q.sclkSync[2];
      end
      if (q.csnSync[2] == q.csnSync[1]) begin
         d.csnF = q.csnSync[2];
      end
      if (q.mosiSync[2] == q.mosiSync[1]) begin
         d.mosiF = q.mosiSync[2];
      end
      sclkRise = d.sclkF & ~q.sclkF;
      sclkFall = ~d.sclkF & q.sclkF;

      if (q.csnF) begin
         d.bitCnt  = 5'h00;
         d.stopped = 1'b0;
      end else if (sclkRise) begin
         d.shiftIn = {q.shiftIn[14:0], q.mosiF};
         d.bitCnt  = q.bitCnt + 5'h01;
         if (q.bitCnt == `INSTR_LAST_BIT) begin
            d.isRead  = instr[15];
            d.addr    = instr[12:0];
            d.outByte = readByte(instr[12:0], q, dieHeat);
         end else if (q.bitCnt == `DATA_LAST_BIT) begin
            d.bitCnt = `BURST_RESUME_BIT;
            if (!q.isRead && !q.stopped) begin
               case (q.addr)
                  `OFS_SERIAL_PORT_SETUP:  d.portSetup = dataByte;
                  `OFS_BURST_STOP_ADDRESS: d.burstStop = dataByte; // RULE_16
                  `OFS_CORE_SELECT_INDEX:  d.coreIndex = dataByte;
                  // host sends wanted ^ old setting, so xor with the old setting lands it
                  `OFS_AUX_OUTPUT_SETTING: d.auxEff = dataByte ^ q.auxEff; // RULE_03
                  `OFS_SETUP_AND_STATE:    d.setupState = dataByte & `SETUP_STATE_MASK; // RULE_01
                  `OFS_PATTERN_SELECT:     d.patSel = dataByte; // RULE_08
                  `OFS_CUSTOM_ONE_LOW:     d.customOne[7:0] = dataByte; // RULE_11
                  `OFS_CUSTOM_ONE_HIGH:    d.customOne[15:8] = dataByte; // RULE_11
                  `OFS_CUSTOM_TWO_LOW:     d.customTwo[7:0] = dataByte; // RULE_12
                  `OFS_CUSTOM_TWO_HIGH:    d.customTwo[15:8] = dataByte; // RULE_12
                  `OFS_HEAT_POWER: begin
                     if (q.coreIndex[`BIT_EXT_PAGE] && dataByte == `HEAT_POWER_ON) begin
                        d.sensorOn = 1'b1; // RULE_13
                     end else if (q.coreIndex[`BIT_EXT_PAGE] &&
                                  dataByte == `HEAT_POWER_OFF) begin
                        d.sensorOn = 1'b0; // RULE_15
                     end
                  end
                  default: begin
                     d.sensorOn = q.sensorOn;
                  end
               endcase
            end
            // burst ends once the stop address has been served
            if (q.addr == {5'h00, q.burstStop}) begin
               d.stopped = 1'b1; // RULE_16
            end else begin
               d.addr = nextAddr;
            end
            if (q.isRead) begin
               d.outByte = readByte(nextAddr, q, dieHeat);
            end
         end
      end else if (sclkFall) begin
         d.miso    = q.outByte[7];
         d.outByte = {q.outByte[6:0], 1'b0};
      end

      // pattern follows the select at the next sample, whatever the link is doing
      d.dataValid = sampleStrobe;
      if (sampleStrobe) begin
         d.phase = ~q.phase;
         if (useWord) begin
            d.word = (altWord && q.phase) ? word2 : word1; // RULE_05 RULE_06
         end else begin
            d.word = 16'(convData) << (16 - OUT_W);
         end
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q            <= '0;
         q.sclkSync   <= 3'h0;
         q.csnSync    <= 3'h7;
         q.csnF       <= 1'b1;
         q.burstStop  <= `RST_BURST_STOP;
         q.patSel     <= `RST_BYTE; // RULE_17
         q.setupState <= `RST_BYTE; // RULE_01
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // outputs
   assign link.miso   = q.miso;
   assign dataOut     = q.word[15 -: OUT_W]; // RULE_17
   assign dataValid   = q.dataValid;
   assign dllSlow     = q.setupState[`BIT_DLL_SLOW]; // RULE_01
   assign ddrEnable   = q.auxEff[`BIT_DDR_ENABLE]; // RULE_03
   assign coreSelect  = q.coreIndex[1:0];
   assign sensorPower = q.sensorOn;

endmodule

// ==== core/adc_cfg_consts.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the converter config link
// Assumes: 13-bit register address, one data byte per 24-bit frame, bursts continue per byte
// Notes:   shared by the device end and the host controller end
//
// Functional notes
// RULE_01: bit 6 picks clock range, fast default
// RULE_02: host picks range matching its sample rate
// RULE_03: ddr and range set through two registers
// RULE_04: host writes aux as read xor wanted
// RULE_05: test pattern replaces data, static or alternating
// RULE_06: pattern change may lag several samples
// RULE_07: custom mode field: static, alternate, reserved
// RULE_08: low nibble selects pattern, zero passes data
// RULE_09: midscale, positive and negative full scale words
// RULE_10: checkerboard and one-zero alternate, others reserved
// RULE_11: custom word one from 0xC2 low, 0xC3 high
// RULE_12: custom word two from 0xC4, 0xC5, second word
// RULE_13: host sets index 0x80, writes 0x88 sensor on
// RULE_14: heat reading returned at 0x11E low, 0x11F high
// RULE_15: host writes 0x60 to power sensor off
// RULE_16: eight-bit register holds burst stop address
// RULE_17: words keep msbs, pattern select resets zero
// RULE_18: reserved codes keep normal data flowing
`ifndef ADC_CFG_CONSTS_SVH
`define ADC_CFG_CONSTS_SVH

// ==========================================================
// register offsets
`define OFS_SERIAL_PORT_SETUP   13'h000
`define OFS_BURST_STOP_ADDRESS  13'h002
`define OFS_PART_IDENTIFIER     13'h008
`define OFS_PART_REVISION       13'h009
`define OFS_CORE_SELECT_INDEX   13'h010
`define OFS_AUX_OUTPUT_SETTING  13'h074
`define OFS_SETUP_AND_STATE     13'h075
`define OFS_PATTERN_SELECT      13'h0C0
`define OFS_CUSTOM_ONE_LOW      13'h0C2
`define OFS_CUSTOM_ONE_HIGH     13'h0C3
`define OFS_CUSTOM_TWO_LOW      13'h0C4
`define OFS_CUSTOM_TWO_HIGH     13'h0C5
`define OFS_HEAT_LOW            13'h11E
`define OFS_HEAT_HIGH           13'h11F
`define OFS_HEAT_POWER          13'h120

// ==========================================================
// fields and values
`define BIT_DLL_SLOW            6
`define BIT_DDR_ENABLE          4
`define BIT_EXT_PAGE            7
`define SETUP_STATE_MASK        8'h40
`define HEAT_POWER_ON           8'h88
`define HEAT_POWER_OFF          8'h60
`define RST_BURST_STOP          8'hFF
`define RST_BYTE                8'h00

// ==========================================================
// test pattern codes and words
`define PAT_OFF                 4'h0
`define PAT_MID                 4'h1
`define PAT_POS                 4'h2
`define PAT_NEG                 4'h3
`define PAT_CHECKER             4'h4
`define PAT_ONE_ZERO            4'h7
`define PAT_CUSTOM              4'h8
`define CUSTOM_STATIC           2'h0
`define CUSTOM_ALTERNATE        2'h1
`define WORD_MID                16'h8000
`define WORD_ONES               16'hFFFF
`define WORD_ZEROS              16'h0000
`define WORD_CHECK_A            16'hAAAA
`define WORD_CHECK_B            16'h5555

// ==========================================================
// frame layout and timing
`define INSTR_LAST_BIT          5'h0F
`define DATA_LAST_BIT           5'h17
`define FRAME_TOP_BIT           5'h17
`define BURST_RESUME_BIT        5'h10
`define CLK_PERIOD_NS           100
`define SCLK_HALF_NS            800
`define SCLK_HALF_CYC           (`SCLK_HALF_NS / `CLK_PERIOD_NS)

// ==========================================================
// host register offsets
`define HOFS_CTRL               8'h00
`define HOFS_STATUS             8'h04
`endif

// ==== core/adc_cfg_pkg.sv ====
// Purpose: state types of both link ends
// Assumes: constants come from adc_cfg_consts.svh
// Notes:   one packed struct per module holds all of its state
package adc_cfg_pkg;

   // ==========================================================
   // device end state
   typedef struct packed {
      logic [2:0]  sclkSync;
      logic [2:0]  csnSync;
      logic [2:0]  mosiSync;
      logic        sclkF;
      logic        csnF;
      logic        mosiF;
      logic [4:0]  bitCnt;
      logic [15:0] shiftIn;
      logic [12:0] addr;
      logic        isRead;
      logic        stopped;
      logic [7:0]  outByte;
      logic        miso;
      logic [7:0]  portSetup;
      logic [7:0]  burstStop;
      logic [7:0]  coreIndex;
      logic [7:0]  auxEff;
      logic [7:0]  setupState;
      logic [7:0]  patSel;
      logic [15:0] customOne;
      logic [15:0] customTwo;
      logic        sensorOn;
      logic        phase;
      logic [15:0] word;
      logic        dataValid;
   } dev_state_type;

   // ==========================================================
   // host end state
   typedef enum logic [3:0] {
      H_IDLE   = 4'b0001,
      H_SHIFT  = 4'b0010,
      H_FINISH = 4'b0100,
      H_GAP    = 4'b1000
   } host_fsm_type;

   typedef struct packed {
      host_fsm_type fsm;
      logic [3:0]   cnt;
      logic [4:0]   bitIdx;
      logic [23:0]  frame;
      logic [7:0]   rx;
      logic [7:0]   rdata;
      logic [2:0]   misoSync;
      logic         misoF;
      logic         sclk;
      logic         csn;
      logic         mosi;
      logic         busy;
      logic         pready;
      logic [31:0]  prdata;
   } host_state_type;

endpackage

// ==== core/spi_link_if.sv ====
// Purpose: serial configuration link between host controller and converter
// Assumes: host makes the link clock, mode 0 framing
// Notes:   no two-way pins; miso is driven at all times by the device
interface spi_link_if;
   logic sclk;
   logic csnN;
   logic mosi;
   logic miso;

   modport dev  (input sclk, input csnN, input mosi, output miso);
   modport host (output sclk, output csnN, output mosi, input miso);
endinterface

// ==== core/spi_host_ctrl.sv ====
// Purpose: host end: APB-programmed controller that runs one link frame per order
// Assumes: link clock made here by a divider, mode 0, one data byte per frame
// Notes:   the xor update and the sensor steps are sequences software issues frame by frame
`include "adc_cfg_consts.svh"

module spi_host_ctrl
   import adc_cfg_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // apb slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   // serial link
   spi_link_if.host         link
);

   localparam logic [3:0] HALF_LAST = 4'(`SCLK_HALF_CYC - 1);

   host_state_type q;
   host_state_type d;
   logic           access;

   // ==========================================================
   // next state
   always_comb begin
      d        = q;
      access   = psel && penable && !q.pready;
      d.pready = access;
      d.misoSync = {q.misoSync[1:0], link.miso};
      if (q.misoSync[2] == q.misoSync[1]) begin
         d.misoF = q.misoSync[2];
      end

      // apb: one wait state; an order lands at the pready edge, dropped while busy
      if (psel && penable && q.pready && pwrite) begin
         if (paddr == `HOFS_CTRL && q.fsm == H_IDLE) begin
            d.frame  = {~pwdata[24], 2'b00, pwdata[20:8], pwdata[7:0]};
            d.fsm    = H_SHIFT;
            d.busy   = 1'b1;
            d.csn    = 1'b0;
            d.mosi   = ~pwdata[24];
            d.bitIdx = `FRAME_TOP_BIT;
            d.cnt    = 4'h0;
         end
      end else if (access && !pwrite) begin
         d.prdata = (paddr == `HOFS_STATUS) ? {16'h0000, q.rdata, 7'h00, q.busy} : 32'h0000_0000;
      end

      case (q.fsm)
         H_IDLE: begin
            d.sclk = 1'b0;
         end
         H_SHIFT: begin
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == HALF_LAST) begin
               d.cnt  = 4'h0;
               d.sclk = ~q.sclk;
               if (q.sclk) begin
                  // sampled late in the high phase to cover both sync chains
                  d.rx = {q.rx[6:0], q.misoF}; // RULE_14
                  if (q.bitIdx == 5'h00) begin
                     d.fsm = H_FINISH;
                  end else begin
                     d.bitIdx = q.bitIdx - 5'h01;
                     d.mosi   = q.frame[q.bitIdx - 5'h01]; // RULE_04 RULE_13 RULE_15
                  end
               end
            end
         end
         H_FINISH: begin
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == HALF_LAST) begin
               d.cnt = 4'h0;
               d.csn = 1'b1;
               d.fsm = H_GAP;
            end
         end
         H_GAP: begin
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == HALF_LAST) begin
               d.cnt   = 4'h0;
               d.rdata = q.rx;
               d.busy  = 1'b0;
               d.fsm   = H_IDLE;
            end
         end
         default: begin
            d.fsm = H_IDLE;
         end
      endcase
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q     <= '0;
         q.fsm <= H_IDLE;
         q.csn <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // outputs
   assign prdata    = q.prdata;
   assign pready    = q.pready;
   assign pslverr   = 1'b0;
   assign link.sclk = q.sclk;
   assign link.csnN = q.csn;
   assign link.mosi = q.mosi;

endmodule

// ==== sim/adc_cfg_link_asserts.sv ====
// Purpose: framing checks on the serial link between the two ends
// Assumes: mode 0 frames of 24 bits, half period of 8 clk
// Notes:   watches the interface signals only
module adc_cfg_link_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // serial link
   input wire logic sclk,
   input wire logic csnN,
   input wire logic mosi,
   input wire logic miso
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // helper: link clock rises within a frame
   logic [5:0] riseCnt_q;
   logic       sclkP_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         riseCnt_q <= 6'h00;
         sclkP_q   <= 1'b0;
      end else begin
         riseCnt_q <= csnN ? 6'h00 : riseCnt_q + 6'(sclk & ~sclkP_q);
         sclkP_q   <= sclk;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // ==========================================
   // properties
   sclk_idle_a: assert property (csnN |-> !sclk)
      else $error("link clock moves outside a frame");
   sclk_changes_a: assert property ($changed(sclk) |-> !csnN)
      else $error("link clock edge without frame select");
   high_half_a: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
      else $error("link clock high phase not 8 cycles");
   low_half_a: assert property ($fell(sclk) |-> !sclk[*7])
      else $error("link clock low phase too short");
   frame_start_a: assert property ($fell(csnN) |-> !sclk[*8] ##1 sclk)
      else $error("first link clock edge misplaced");
   bit_count_a: assert property ($rose(csnN) |-> riseCnt_q == 6'h18)
      else $error("frame not 24 bits long");
   frame_gap_a: assert property ($rose(csnN) |-> csnN[*8])
      else $error("frames too close together");
   mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
      else $error("host data moves while clock high");
   miso_hold_a: assert property (!csnN && sclk && $past(sclk) |-> $stable(miso))
      else $error("device data moves while clock high");
endmodule

// ==== sim/adc_config_test_pattern_regs_tb.sv ====
// Purpose: host controller and device end joined, driven over APB
// Assumes: OUT_W 12, device identity parameters left at their defaults
// Notes:   pattern words checked from a queue by a watching process
module adc_config_test_pattern_regs_tb
   import adc_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, sampleStrobe;
   logic dataValid, dllSlow, ddrEnable, sensorPower, rdChk, ph;
   logic [7:0]  paddr, sel, rb, s, a;
   logic [31:0] pwdata, prdata, r32;
   logic [11:0] convData, dataOut;
   logic [15:0] dieHeat, c1, c2;
   logic [1:0]  coreSelect;
   logic [15:0] patQ[$];
   logic [7:0]  regQ[$];
   int          miscompares, checked;

   always #50 clk = ~clk;
   spi_link_if spi_link_if_i ();
   adc_cfg_device #(.OUT_W(12)) adc_cfg_device_i (.clk(clk), .resetn(resetn),
      .link(spi_link_if_i), .convData(convData), .sampleStrobe(sampleStrobe),
      .dieHeat(dieHeat), .dataOut(dataOut), .dataValid(dataValid), .dllSlow(dllSlow),
      .ddrEnable(ddrEnable), .coreSelect(coreSelect), .sensorPower(sensorPower));
   spi_host_ctrl spi_host_ctrl_i (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(spi_link_if_i));
   adc_cfg_link_asserts adc_cfg_link_asserts_i (.clk(clk), .resetn(resetn),
      .sclk(spi_link_if_i.sclk), .csnN(spi_link_if_i.csnN),
      .mosi(spi_link_if_i.mosi), .miso(spi_link_if_i.miso));

   // ==========================================
   // compare, close
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // top 12 bits of the chosen 16-bit word, normal data msb-aligned
   function automatic logic [15:0] expw(logic [7:0] sl, logic p, logic [11:0] cd);
      logic [15:0] w;
      case (sl[3:0])
         4'h1: w = 16'h8000;
         4'h2: w = 16'hFFFF;
         4'h3: w = 16'h0000;
         4'h4: w = p ? 16'h5555 : 16'hAAAA;
         4'h7: w = p ? 16'h0000 : 16'hFFFF;
         4'h8: w = sl[7:6] == 2'h0 ? c1 : sl[7:6] == 2'h1 ? (p ? c2 : c1) : {cd, 4'h0};
         default: w = {cd, 4'h0};
      endcase
      return {4'h0, w[15:4]};
   endfunction

   // ==========================================
   // apb master and link frames
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                      output logic [31:0] r);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // no limit here: the watchdog ends a slave that never answers
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic frame(input logic w, input logic [12:0] ad, input logic [7:0] d,
                        output logic [7:0] r);
      logic [31:0] st;
      apb(1'b1, 8'h00, {7'h00, w, 3'h0, ad, d}, st);
      st = 32'h1;
      // busy poll; the watchdog bounds a link that never finishes
      while (st[0] !== 1'b0) apb(1'b0, 8'h04, 32'h0, st);
      r = st[15:8];
   endtask
   task automatic wrr(input logic [12:0] ad, input logic [7:0] d);
      frame(1'b1, ad, d, rb);
   endtask
   task automatic rdc(input logic [12:0] ad, input logic [7:0] e);
      regQ.push_back(e);
      rdChk = 1'b1;
      frame(1'b0, ad, 8'h00, rb);
      rdChk = 1'b0;
   endtask
   task automatic strobe(input int n);
      repeat (n) begin
         convData <= 12'($urandom);
         sampleStrobe <= 1'b1;
         @(posedge clk);
         patQ.push_back(expw(sel, ph, convData));
         ph = ~ph;
         sampleStrobe <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask

   // ==========================================
   // watcher of results
   always @(posedge clk) begin
      if (dataValid === 1'b1) check({4'h0, dataOut}, patQ.pop_front());
      if (pready === 1'b1 && rdChk && !pwrite && paddr == 8'h04 && prdata[0] === 1'b0)
         check({8'h00, prdata[15:8]}, {8'h00, regQ.pop_front()});
   end
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      summarize();
   end

   // ==========================================
   // main sequence
   initial begin
      clk = 0; resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      convData = 0; sampleStrobe = 0; rdChk = 0; ph = 0; sel = 0;
      miscompares = 0; checked = 0;
      void'($urandom(62711));
      dieHeat = 16'($urandom);
      c1 = 16'($urandom);
      c2 = 16'($urandom);
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      apb(1'b0, 8'h08, 32'h0, r32);
      check(r32[15:0], 16'h0000);
      check(16'(pslverr), 16'h0000);
      rdc(13'h008, 8'h5A);
      rdc(13'h002, 8'hFF);
      rdc(13'h0C0, 8'h00);
      s = 8'($urandom);
      wrr(13'h002, s);
      rdc(13'h002, s);
      check(16'(dllSlow), 16'h0000);
      wrr(13'h075, 8'hFF);
      rdc(13'h075, 8'h40);
      check(16'(dllSlow), 16'h0001);
      frame(1'b0, 13'h074, 8'h00, a);
      frame(1'b0, 13'h075, 8'h00, s);
      wrr(13'h074, a ^ s ^ 8'h10);
      check(16'(ddrEnable), 16'h0001);
      rdc(13'h074, 8'h10 ^ s);
      wrr(13'h0C2, c1[7:0]);
      wrr(13'h0C3, c1[15:8]);
      wrr(13'h0C4, c2[7:0]);
      wrr(13'h0C5, c2[15:8]);
      // codes 0..8 static mode, then custom modes 1..3 on code 8
      for (int i = 0; i < 12; i++) begin
         sel = i < 9 ? {4'h0, 4'(i)} : {2'(i - 8), 2'h0, 4'h8};
         wrr(13'h0C0, sel);
         strobe(4);
      end
      wrr(13'h010, 8'h83);
      check(16'(coreSelect), 16'h0003);
      wrr(13'h010, 8'h80);
      rdc(13'h11E, 8'h00);
      wrr(13'h120, 8'h88);
      check(16'(sensorPower), 16'h0001);
      rdc(13'h11E, dieHeat[7:0]);
      rdc(13'h11F, dieHeat[15:8]);
      rdc(13'h120, 8'h00);
      wrr(13'h120, 8'h60);
      check(16'(sensorPower), 16'h0000);
      summarize();
   end
endmodule
